// ==== rtl/scs_defs.svh ====
`ifndef SCS_DEFS_SVH
`define SCS_DEFS_SVH

// Register byte offsets.
`define SCS_A_CTRL 5'h00
`define SCS_A_STAT 5'h04
`define SCS_A_DIV 5'h08
`define SCS_A_TXD 5'h0c
`define SCS_A_RXD 5'h10
`define SCS_A_IST 5'h14
`define SCS_A_IMSK 5'h18

// Control register fields.
`define SCS_C_IOM 0
`define SCS_C_DBUF 2
`define SCS_C_ORDER 3
`define SCS_C_STOP2 4

// Status register fields.
`define SCS_S_TXRUN 5
`define SCS_S_RBFULL 6
`define SCS_S_TBEMP 7

// Interrupt status and mask fields.
`define SCS_I_RX 0
`define SCS_I_TX 1
`define SCS_I_FERR 2

// Reset values and counts.
`define SCS_DIV_RST 16'h043d
`define SCS_LAST_BIT 3'h7
`define SCS_ONE16 16'h0001

`endif

// ==== rtl/scs_pkg.sv ====
package scs_pkg;

    // Gray sequence idle, start, data, stop.
    typedef enum logic [1:0] {
        SCS_IDLE = 2'b00,
        SCS_START = 2'b01,
        SCS_DATA = 2'b11,
        SCS_STOP = 2'b10
    } scs_bit_st_t;

endpackage

// ==== rtl/scs_tx.sv ====
`timescale 1ns/100ps
`include "scs_defs.svh"
module scs_tx (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Setup
    input wire logic [15:0] div,
    input wire logic io_mode,
    input wire logic two_stop,
    // Word in
    input wire logic start,
    input wire logic [7:0] data,
    // Line and status
    output logic txd_q,
    output logic sclk_q,
    output logic busy_q,
    output logic done_q
);
    import scs_pkg::*;

    scs_bit_st_t st_q;
    logic [15:0] cnt_q;
    logic [2:0] idx_q;
    logic [7:0] sh_q;
    logic extra_q;
    logic tick;

    assign tick = (cnt_q == 16'h0000);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= SCS_IDLE;
            cnt_q <= 16'h0000;
            idx_q <= 3'h0;
            sh_q <= 8'h00;
            extra_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            cnt_q <= tick ? div : 16'(cnt_q - `SCS_ONE16);
            case (st_q)
                SCS_IDLE: begin
                    if (start) begin
                        sh_q <= data;
                        cnt_q <= div;
                        idx_q <= 3'h0;
                        extra_q <= two_stop & ~io_mode;
                        st_q <= io_mode ? SCS_DATA : SCS_START;
                    end
                end
                SCS_START: if (tick) st_q <= SCS_DATA;
                SCS_DATA: begin
                    if (tick) begin
                        sh_q <= {1'b0, sh_q[7:1]};
                        idx_q <= 3'(idx_q + 3'h1);
                        if (idx_q == `SCS_LAST_BIT) begin
                            st_q <= io_mode ? SCS_IDLE : SCS_STOP;
                            done_q <= io_mode;
                        end
                    end
                end
                SCS_STOP: begin
                    if (tick && extra_q) begin
                        extra_q <= 1'b0;
                    end else if (tick) begin
                        st_q <= SCS_IDLE;
                        done_q <= 1'b1;
                    end
                end
                default: st_q <= SCS_IDLE;
            endcase
        end
    end

    // Line level and clock follow the state one cycle later.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            txd_q <= 1'b1;
            sclk_q <= 1'b1;
            busy_q <= 1'b0;
        end else begin
            txd_q <= (st_q == SCS_START) ? 1'b0 : (st_q == SCS_DATA) ? sh_q[0] : 1'b1;
            sclk_q <= !(st_q == SCS_DATA && io_mode && cnt_q > {1'b0, div[15:1]});
            busy_q <= (st_q != SCS_IDLE);
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_stop_len;
        (st_q == SCS_STOP && tick) |=> (st_q == ($past(extra_q) ? SCS_STOP : SCS_IDLE));
    endproperty
    a_stop_len: assert property (p_stop_len) else $error("stop bit count wrong");
endmodule

// ==== rtl/scs_rx.sv ====
`timescale 1ns/100ps
`include "scs_defs.svh"
module scs_rx (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Setup
    input wire logic [15:0] div,
    input wire logic io_mode,
    input wire logic go,
    // Line, already synchronised
    input wire logic rxd,
    // Word out
    output logic [7:0] word_q,
    output logic done_q,
    output logic ferr_q
);
    import scs_pkg::*;

    scs_bit_st_t st_q;
    logic [15:0] cnt_q;
    logic [2:0] idx_q;
    logic [7:0] sh_q;
    logic tick;

    assign tick = (cnt_q == 16'h0000);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= SCS_IDLE;
            cnt_q <= 16'h0000;
            idx_q <= 3'h0;
            sh_q <= 8'h00;
            word_q <= 8'h00;
            done_q <= 1'b0;
            ferr_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            ferr_q <= 1'b0;
            cnt_q <= tick ? div : 16'(cnt_q - `SCS_ONE16);
            case (st_q)
                SCS_IDLE: begin
                    // Sampling lands near mid-bit, where the line is steadiest.
                    cnt_q <= {1'b0, div[15:1]};
                    idx_q <= 3'h0;
                    if (io_mode ? go : !rxd) st_q <= io_mode ? SCS_DATA : SCS_START;
                end
                SCS_START: if (tick) st_q <= rxd ? SCS_IDLE : SCS_DATA;
                SCS_DATA: begin
                    if (tick) begin
                        sh_q <= {rxd, sh_q[7:1]};
                        idx_q <= 3'(idx_q + 3'h1);
                        if (idx_q == `SCS_LAST_BIT) begin
                            st_q <= io_mode ? SCS_IDLE : SCS_STOP;
                            word_q <= {rxd, sh_q[7:1]};
                            done_q <= io_mode;
                        end
                    end
                end
                SCS_STOP: begin
                    if (tick) begin
                        st_q <= SCS_IDLE;
                        done_q <= 1'b1;
                        ferr_q <= !rxd;
                    end
                end
                default: st_q <= SCS_IDLE;
            endcase
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_one_stop;
        (st_q == SCS_STOP && tick) |=> (done_q && ferr_q == !$past(rxd) && st_q == SCS_IDLE);
    endproperty
    a_one_stop: assert property (p_one_stop) else $error("stop check wrong");
endmodule

// ==== rtl/scs_top.sv ====
// What this block does
// - Completed receive into buffer sets full flag.
// - Reading full flag returns it, then clears.
// - Transmit-active reads one while sending.
// - Active and empty flags encode transmit status.
// - Stop-length field picks one or two stops.
// - Receiver checks exactly one stop bit.
// - Bit order field picks LSB or MSB first in clocked mode; UART frames always go LSB first.
// - Double-buffer field switches buffering off or on.
`timescale 1ns/100ps
`include "scs_defs.svh"
module scs_top (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Serial line
    input wire logic ser_in,
    output logic ser_out,
    output logic ser_clk,
    // Interrupt
    output logic irq
);
    import scs_pkg::*;

    function automatic logic [7:0] rev8(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[7 - i];
        end
        return r;
    endfunction

    logic [1:0] rst_sync_q;
    logic rst_n;
    logic [1:0] in_sync_q;
    logic rxd;

    logic ack_q;
    logic req;
    logic wr_acc;
    logic rd_acc;

    logic io_mode_q;
    logic double_buffer_enable;
    logic bit_order_select;
    logic stop2_q;
    logic [15:0] div_q;

    logic [7:0] tx_buf_q;
    logic tx_buf_full_q;
    logic tx_start_q;
    logic [7:0] tx_word_q;
    logic [1:0] pend_q;
    logic tx_idle;
    logic tx_busy;
    logic tx_done;
    logic tx_line;
    logic tx_clk;

    logic [7:0] rx_word;
    logic rx_done;
    logic rx_ferr;
    logic [7:0] rx_data_q;
    logic rx_buffer_full_flag;

    logic [2:0] ist_q;
    logic [2:0] imsk_q;
    logic [2:0] ev;
    logic [31:0] rd_d;

    // Reset is released through two flops; assertion stays asynchronous.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // The serial input is asynchronous to mclk.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            in_sync_q <= 2'b11;
        end else begin
            in_sync_q <= {in_sync_q[0], ser_in};
        end
    end
    assign rxd = in_sync_q[1];

    // Bus handshake: one wait state, ack dropped after one cycle.
    assign req = wb_cyc_i & wb_stb_i;
    assign wr_acc = req & wb_we_i & ack_q;
    assign rd_acc = req & ~wb_we_i & ack_q;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end
    assign wb_ack_o = ack_q;

    // Control, divider and interrupt mask writes.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            io_mode_q <= 1'b0;
            double_buffer_enable <= 1'b0;
            bit_order_select <= 1'b0;
            stop2_q <= 1'b0;
            div_q <= `SCS_DIV_RST;
            imsk_q <= 3'h0;
        end else if (wr_acc) begin
            if (wb_adr_i == `SCS_A_CTRL && wb_sel_i[0]) begin
                io_mode_q <= wb_dat_i[`SCS_C_IOM];
                double_buffer_enable <= wb_dat_i[`SCS_C_DBUF];
                bit_order_select <= wb_dat_i[`SCS_C_ORDER];
                stop2_q <= wb_dat_i[`SCS_C_STOP2];
            end
            if (wb_adr_i == `SCS_A_DIV && wb_sel_i[0]) div_q[7:0] <= wb_dat_i[7:0];
            if (wb_adr_i == `SCS_A_DIV && wb_sel_i[1]) div_q[15:8] <= wb_dat_i[15:8];
            if (wb_adr_i == `SCS_A_IMSK && wb_sel_i[0]) imsk_q <= wb_dat_i[2:0];
        end
    end

    // The launch takes two cycles to show in busy, so pend covers the gap.
    assign tx_idle = !tx_busy && pend_q == 2'b00 && !tx_start_q;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pend_q <= 2'b00;
        end else begin
            pend_q <= {pend_q[0], tx_start_q};
        end
    end

    // Transmit holding buffer and launch.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tx_buf_q <= 8'h00;
            tx_buf_full_q <= 1'b0;
            tx_start_q <= 1'b0;
            tx_word_q <= 8'h00;
        end else begin
            tx_start_q <= 1'b0;
            if (double_buffer_enable && tx_buf_full_q && tx_idle) begin
                tx_start_q <= 1'b1;
                tx_word_q <= (io_mode_q && bit_order_select) ? rev8(tx_buf_q) : tx_buf_q;
                tx_buf_full_q <= 1'b0;
            end
            if (wr_acc && wb_adr_i == `SCS_A_TXD && wb_sel_i[0]) begin
                if (double_buffer_enable && !tx_buf_full_q) begin
                    tx_buf_q <= wb_dat_i[7:0];
                    tx_buf_full_q <= 1'b1;
                end else if (!double_buffer_enable && tx_idle) begin
                    tx_start_q <= 1'b1;
                    tx_word_q <= (io_mode_q && bit_order_select) ? rev8(wb_dat_i[7:0]) : wb_dat_i[7:0];
                end
            end
            if (!double_buffer_enable) tx_buf_full_q <= 1'b0;
        end
    end

    scs_tx u_tx (
        .mclk(mclk),
        .rst_n(rst_n),
        .div(div_q),
        .io_mode(io_mode_q),
        .two_stop(stop2_q),
        .start(tx_start_q),
        .data(tx_word_q),
        .txd_q(tx_line),
        .sclk_q(tx_clk),
        .busy_q(tx_busy),
        .done_q(tx_done)
    );

    // In clocked mode the receiver shifts alongside every transmitted word.
    scs_rx u_rx (
        .mclk(mclk),
        .rst_n(rst_n),
        .div(div_q),
        .io_mode(io_mode_q),
        .go(tx_start_q & io_mode_q),
        .rxd(rxd),
        .word_q(rx_word),
        .done_q(rx_done),
        .ferr_q(rx_ferr)
    );

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ser_out <= 1'b1;
            ser_clk <= 1'b1;
        end else begin
            ser_out <= tx_line;
            ser_clk <= tx_clk;
        end
    end

    // Received word and full flag; a new word beats a clearing read.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_data_q <= 8'h00;
            rx_buffer_full_flag <= 1'b0;
        end else begin
            if (rd_acc && wb_adr_i == `SCS_A_STAT) rx_buffer_full_flag <= 1'b0;
            if (rx_done) begin
                rx_data_q <= (io_mode_q && bit_order_select) ? rev8(rx_word) : rx_word;
                if (double_buffer_enable) rx_buffer_full_flag <= 1'b1;
            end
            if (!double_buffer_enable) rx_buffer_full_flag <= 1'b0;
        end
    end

    // Sticky events, write one to clear; a new event wins.
    assign ev = {rx_ferr, tx_done, rx_done};

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ist_q <= 3'h0;
            irq <= 1'b0;
        end else begin
            if (wr_acc && wb_adr_i == `SCS_A_IST && wb_sel_i[0]) begin
                ist_q <= (ist_q & ~wb_dat_i[2:0]) | ev;
            end else begin
                ist_q <= ist_q | ev;
            end
            irq <= |(ist_q & imsk_q);
        end
    end

    // Read mux; unmapped offsets read zero.
    always_comb begin
        rd_d = 32'h0000_0000;
        case (wb_adr_i)
            `SCS_A_CTRL: begin
                rd_d[`SCS_C_IOM] = io_mode_q;
                rd_d[`SCS_C_DBUF] = double_buffer_enable;
                rd_d[`SCS_C_ORDER] = bit_order_select;
                rd_d[`SCS_C_STOP2] = stop2_q;
            end
            `SCS_A_STAT: begin
                rd_d[`SCS_S_TXRUN] = tx_busy;
                rd_d[`SCS_S_TBEMP] = !tx_buf_full_q;
                rd_d[`SCS_S_RBFULL] = rx_buffer_full_flag;
            end
            `SCS_A_DIV: rd_d[15:0] = div_q;
            `SCS_A_RXD: rd_d[7:0] = rx_data_q;
            `SCS_A_IST: rd_d[2:0] = ist_q;
            `SCS_A_IMSK: rd_d[2:0] = imsk_q;
            default: rd_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req && !ack_q && !wb_we_i) begin
            wb_dat_o <= rd_d;
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_rbf_set;
        (rx_done && double_buffer_enable) |=> rx_buffer_full_flag;
    endproperty
    a_rbf_set: assert property (p_rbf_set) else $error("full flag not set");

    property p_rbf_clr;
        (rd_acc && wb_adr_i == `SCS_A_STAT && !rx_done) |=> !rx_buffer_full_flag;
    endproperty
    a_rbf_clr: assert property (p_rbf_clr) else $error("full flag not cleared");

    property p_run_rise;
        tx_start_q |-> ##2 tx_busy;
    endproperty
    a_run_rise: assert property (p_run_rise) else $error("active flag late");

    property p_stat_rd;
        (ack_q && !wb_we_i && $past(wb_adr_i) == `SCS_A_STAT && $past(req))
            |-> (wb_dat_o[`SCS_S_TXRUN] == $past(tx_busy) && wb_dat_o[`SCS_S_TBEMP] == !$past(tx_buf_full_q));
    endproperty
    a_stat_rd: assert property (p_stat_rd) else $error("status bits wrong");

    property p_order;
        (rx_done && io_mode_q && bit_order_select) |=> rx_data_q == rev8($past(rx_word));
    endproperty
    a_order: assert property (p_order) else $error("bit order wrong");

    property p_nobuf;
        !double_buffer_enable |=> !tx_buf_full_q;
    endproperty
    a_nobuf: assert property (p_nobuf) else $error("buffer used while off");

    property p_direct;
        (rx_done && !double_buffer_enable) |=> (rx_data_q == $past(rx_word) || bit_order_select);
    endproperty
    a_direct: assert property (p_direct) else $error("direct delivery failed");

    property p_irq;
        (|(ist_q & imsk_q)) |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing");

    property p_tx_stage;
        (wr_acc && wb_adr_i == `SCS_A_TXD && wb_sel_i[0] && double_buffer_enable && !tx_buf_full_q)
            |=> tx_buf_full_q;
    endproperty
    a_tx_stage: assert property (p_tx_stage) else $error("write not staged");

    property p_tx_direct;
        (wr_acc && wb_adr_i == `SCS_A_TXD && wb_sel_i[0] && !double_buffer_enable && tx_idle) |=> tx_start_q;
    endproperty
    a_tx_direct: assert property (p_tx_direct) else $error("direct launch missing");

    property p_rbf_hold;
        (rx_buffer_full_flag && double_buffer_enable && !(rd_acc && wb_adr_i == `SCS_A_STAT))
            |=> rx_buffer_full_flag;
    endproperty
    a_rbf_hold: assert property (p_rbf_hold) else $error("full flag lost");
endmodule

// ==== test/scs_remote.sv ====
`timescale 1ns/100ps
module scs_remote (
    // Clock
    input wire logic mclk,
    // Lines from the block
    input wire logic ser_out,
    input wire logic ser_clk,
    // Line to the block
    output logic ser_in
);
    logic [7:0] clk_cap = 8'h00;
    logic [7:0] clk_src = 8'hff;
    logic clk_prev = 1'b1;

    initial ser_in = 1'b1;

    // The block masters the clocked link, so we sample on its rise and shift on its fall.
    always @(posedge mclk) begin
        clk_prev <= ser_clk;
        if (!clk_prev && ser_clk) begin
            clk_cap <= {clk_cap[6:0], ser_out};
        end
        if (clk_prev && !ser_clk) begin
            ser_in <= clk_src[0];
            clk_src <= {1'b1, clk_src[7:1]};
        end
    end

    // One frame, LSB first, one stop bit that may be forced low on purpose.
    task automatic send_uart(input logic [7:0] d, input logic bad_stop, input int p);
        logic [9:0] f;
        f = {~bad_stop, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            ser_in <= f[i];
            repeat (p) @(posedge mclk);
        end
        ser_in <= 1'b1;
    endtask

    // Samples mid-bit; hi counts high cycles from mid last bit to next start, or is -1 with no start bit.
    task automatic catch_uart(input int p, output logic [7:0] d, output int hi);
        int n;
        n = 0;
        while (ser_out !== 1'b0 && n < 4000) begin
            @(posedge mclk);
            n++;
        end
        hi = -1;
        if (ser_out !== 1'b0) return;
        repeat (p / 2) @(posedge mclk);
        for (int i = 0; i < 8; i++) begin
            repeat (p) @(posedge mclk);
            d[i] = ser_out;
        end
        hi = 0;
        while (ser_out !== 1'b0 && hi < 4 * p) begin
            @(posedge mclk);
            hi++;
        end
    endtask
endmodule

// ==== test/scs_top_tb.sv ====
`timescale 1ns/100ps
`include "scs_defs.svh"
module scs_top_tb;
    localparam int P = 16;
    logic mclk;
    logic nrst = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [4:0] wb_adr_i = 5'h00;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic ser_in;
    logic ser_out;
    logic ser_clk;
    logic irq;
    logic [31:0] q;
    logic [7:0] d1;
    logic [7:0] d2;
    int h1;
    int h2;
    int fail_count = 0;
    int cmp_count = 0;

    scs_top u_scs_top (.mclk(mclk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .ser_in(ser_in), .ser_out(ser_out), .ser_clk(ser_clk), .irq(irq));
    scs_remote u_scs_remote (.mclk(mclk), .ser_out(ser_out), .ser_clk(ser_clk), .ser_in(ser_in));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic final_report();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask

    task automatic tmo(input string what);
        $display("CHECK FAILED %s expected done seen timeout", what);
        fail_count++;
        final_report();
    endtask

    // One classic cycle; read data lands in q at the ack edge.
    task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_sel_i <= 4'hf;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge mclk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 16);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            tmo("bus ack");
        end
    endtask

    // Polls the active flag; the first read is delayed so a fresh start is seen.
    task automatic wait_idle();
        int n;
        n = 0;
        repeat (8) @(posedge mclk);
        do begin
            wb(1'b0, `SCS_A_STAT, 32'h0);
            n++;
        end while (q[`SCS_S_TXRUN] !== 1'b0 && n < 400);
        if (q[`SCS_S_TXRUN] !== 1'b0) begin
            tmo("transmit idle");
        end
    endtask

    task automatic t_reset();
        wb(1'b0, `SCS_A_CTRL, 32'h0);
        chk("ctrl reset", 32'h0, q);
        wb(1'b0, `SCS_A_STAT, 32'h0);
        chk("stat reset", 32'h80, q);
        wb(1'b0, `SCS_A_DIV, 32'h0);
        chk("div reset", {16'h0, `SCS_DIV_RST}, q);
        wb(1'b0, 5'h1c, 32'h0);
        chk("unmapped read", 32'h0, q);
        wb(1'b1, `SCS_A_DIV, P - 1);
    endtask

    task automatic t_tx(input logic two);
        wb(1'b1, `SCS_A_CTRL, {27'h0, two, 4'h4});
        fork
            begin
                wb(1'b1, `SCS_A_TXD, 32'ha5);
                wb(1'b1, `SCS_A_TXD, 32'h3c);
                wb(1'b0, `SCS_A_STAT, 32'h0);
                chk("stat busy with data held", 32'h20, q & 32'he0);
            end
            begin
                u_scs_remote.catch_uart(P, d1, h1);
                u_scs_remote.catch_uart(P, d2, h2);
            end
        join
        if (h1 < 0 || h2 < 0) begin
            tmo("uart frame");
        end
        chk("tx first word", 32'ha5, {24'h0, d1});
        chk("tx second word", 32'h3c, {24'h0, d2});
        chk("stop cycles", (P / 2 + (two + 1) * P + 2) / 8, (h1 + 2) / 8);
        wait_idle();
        chk("stat completed", 32'h80, q & 32'he0);
        wb(1'b0, `SCS_A_IST, 32'h0);
        chk("tx done event", 32'h2, q & 32'h2);
        wb(1'b1, `SCS_A_IST, 32'h7);
    endtask

    task automatic t_rx(input logic dbuf);
        wb(1'b1, `SCS_A_CTRL, {27'h0, 2'b10, dbuf, 2'b00});
        wb(1'b1, `SCS_A_IST, 32'h7);
        @(posedge mclk);
        u_scs_remote.send_uart(8'h5a, 1'b0, P);
        u_scs_remote.send_uart(8'hc3, 1'b0, P);
        repeat (4) @(posedge mclk);
        wb(1'b0, `SCS_A_IST, 32'h0);
        chk("rx without stop error", 32'h1, q & 32'h5);
        wb(1'b0, `SCS_A_STAT, 32'h0);
        chk("full and empty flags", {24'h0, 1'b1, dbuf, 6'h0}, q & 32'hc0);
        wb(1'b0, `SCS_A_STAT, 32'h0);
        chk("full after read", 32'h0, q & 32'h40);
        wb(1'b0, `SCS_A_RXD, 32'h0);
        chk("rx word", 32'hc3, q & 32'hff);
        u_scs_remote.send_uart(8'h81, 1'b1, P);
        repeat (4) @(posedge mclk);
        wb(1'b0, `SCS_A_IST, 32'h0);
        chk("stop error", 32'h4, q & 32'h4);
        wb(1'b0, `SCS_A_RXD, 32'h0);
        chk("rx word after error", 32'h81, q & 32'hff);
        // A broken stop may look like a start, so let any stray frame run out.
        repeat (12 * P) @(posedge mclk);
        wb(1'b1, `SCS_A_IST, 32'h7);
    endtask

    task automatic t_clk(input logic msb);
        wb(1'b1, `SCS_A_CTRL, {28'h0, msb, 3'b001});
        u_scs_remote.clk_src <= 8'h9d;
        wb(1'b1, `SCS_A_TXD, 32'hb4);
        wait_idle();
        chk("clocked tx order", msb ? 32'hb4 : 32'h2d, {24'h0, u_scs_remote.clk_cap});
        wb(1'b0, `SCS_A_RXD, 32'h0);
        chk("clocked rx order", msb ? 32'hb9 : 32'h9d, q & 32'hff);
    endtask

    task automatic t_irq();
        wb(1'b1, `SCS_A_CTRL, 32'h0);
        wb(1'b1, `SCS_A_IMSK, 32'h0);
        wb(1'b1, `SCS_A_IST, 32'h7);
        @(posedge mclk);
        u_scs_remote.send_uart(8'h11, 1'b0, P);
        repeat (4) @(posedge mclk);
        wb(1'b0, `SCS_A_IST, 32'h0);
        chk("rx event", 32'h1, q & 32'h7);
        chk("irq masked", 32'h0, {31'h0, irq});
        wb(1'b1, `SCS_A_IMSK, 32'h1);
        repeat (2) @(posedge mclk);
        chk("irq raised", 32'h1, {31'h0, irq});
        wb(1'b1, `SCS_A_IST, 32'h1);
        repeat (2) @(posedge mclk);
        chk("irq cleared", 32'h0, {31'h0, irq});
    endtask

    initial begin
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
        t_reset();
        t_tx(1'b0);
        t_tx(1'b1);
        t_rx(1'b0);
        t_rx(1'b1);
        t_clk(1'b0);
        t_clk(1'b1);
        t_irq();
        final_report();
    end
endmodule
